// >>> frch_defines.vh
// Constants for the flag register command handler.
// Assumes inclusion by the handler and its reply sender only.
`ifndef FRCH_DEFINES_VH
`define FRCH_DEFINES_VH

// Framing and answer characters
`define FRCH_STX 8'h02
`define FRCH_ETX 8'h03
`define FRCH_ACK 8'h06
`define FRCH_NAK 8'h15

// Command letters
`define FRCH_CH_W 8'h57
`define FRCH_CH_R 8'h52
`define FRCH_CH_M 8'h4D
`define FRCH_CH_F 8'h46
`define FRCH_CH_C 8'h43
`define FRCH_CH_H 8'h48
`define FRCH_CH_L 8'h4C
`define FRCH_CH_S 8'h53
`define FRCH_CH_T 8'h54
`define FRCH_CH_P 8'h50
`define FRCH_CH_A 8'h41
`define FRCH_CH_0 8'h30
`define FRCH_CH_9 8'h39

// Frame body store depth and reply size
`define FRCH_BODY_MAX 4'h8
`define FRCH_REPLY_BYTES 12
`define FRCH_REPLY_W 96

// Reset values
`define FRCH_FLAG_RST 16'h0000
`define FRCH_CFG_H_RST 16'h0000
`define FRCH_CFG_L_RST 16'h0000
`define FRCH_SW_RST 8'h30

`endif

// >>> frch_reply_tx.v
// Reply sender: holds one framed reply and hands it out byte by byte.
// Assumes a byte sink with valid/ready on the same clock.
`timescale 1ns/1ps
`include "frch_defines.vh"

module frch_reply_tx (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire load_i,
  input wire [3:0] len_i,
  input wire [`FRCH_REPLY_W-1:0] bytes_i,
  input wire tx_ready_i,
  output wire [7:0] tx_data_o,
  output wire tx_valid_o,
  output wire busy_o
);
  reg [`FRCH_REPLY_W-1:0] shift_ff;
  reg [3:0] left_ff;

  assign tx_data_o = shift_ff[7:0];
  assign tx_valid_o = (left_ff != 4'h0);
  assign busy_o = tx_valid_o;

  // Byte 0 goes first; load is only issued while idle
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_ff <= {`FRCH_REPLY_W{1'b0}};
      left_ff <= 4'h0;
    end else if (load_i) begin
      shift_ff <= bytes_i;
      left_ff <= len_i;
    end else if (tx_valid_o && tx_ready_i) begin
      shift_ff <= {8'h00, shift_ff[`FRCH_REPLY_W-1:8]};
      left_ff <= left_ff - 4'h1;
    end
  end
endmodule

// >>> frch_cmd_handler.v
// Framed ASCII command handler for the mode flag, configuration and
// mode-switch registers, with temperature readback.
// Assumes a byte receiver and transmitter on mclk_i with valid/ready.
// Operation
// (RULE1) Mode-flag write frame with four hex characters loads the flag word.
// (RULE2) Mode-flag write touches only the volatile register, never memory.
// (RULE3) Write commands answer STX ACK ETX, or STX NAK ETX on rejection.
// (RULE4) Config read H/L answers ACK, letters, selector, four hex chars.
// (RULE5) Mode-flag read answers ACK, letters, four hex chars of flag word.
// (RULE6) Config save copies configuration word to memory, then acknowledges.
// (RULE7) Temperature read answers ACK, letters, temperature in hex.
// (RULE8) Temperature word is 16 bits, only low 10 bits meaningful.
// (RULE9) Temperature field is signed two's complement, at most 511.
// (RULE10) Switch read answers ACK and one position character, or NAK.
// (RULE11) Switch write sets position from one character and acknowledges.
// (RULE12) Config write H/L loads four hex chars into chosen half.
// (RULE13) Page save stores the full setting at the given page letter.
// (RULE14) Bad hex, wrong length or bad selector gets NAK, no change.
`timescale 1ns/1ps
`include "frch_defines.vh"

module frch_cmd_handler (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  output wire rx_ready_o,
  output wire [7:0] tx_data_o,
  output wire tx_valid_o,
  input wire tx_ready_i,
  input wire [9:0] temp_data_i,
  output wire [15:0] flag_word_o,
  output wire [15:0] cfg_high_o,
  output wire [15:0] cfg_low_o,
  output wire [7:0] switch_pos_o,
  output wire cfg_save_o,
  output wire page_save_o,
  output wire [7:0] page_sel_o
);
  // Hex character to nibble; bit 4 marks a legal digit
  function [4:0] hex_val;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        hex_val = {1'b1, c[3:0]};
      else if (c >= 8'h41 && c <= 8'h46)
        hex_val = {1'b1, c[3:0] + 4'h9};
      else if (c >= 8'h61 && c <= 8'h66)
        hex_val = {1'b1, c[3:0] + 4'h9};
      else
        hex_val = 5'h00;
    end
  endfunction

  // Nibble to upper-case hex character
  function [7:0] hex_chr;
    input [3:0] n;
    begin
      if (n < 4'hA)
        hex_chr = {4'h0, n} + 8'h30;
      else
        hex_chr = {4'h0, n} + 8'h37;
    end
  endfunction

  reg [7:0] body_ff [0:7];
  reg [3:0] cnt_ff;
  reg in_frame_ff;
  reg ovf_ff;
  reg exec_ff;
  reg [15:0] flag_ff;
  reg [15:0] cfg_h_ff;
  reg [15:0] cfg_l_ff;
  reg [7:0] sw_ff;
  reg cfg_save_ff;
  reg page_save_ff;
  reg [7:0] page_ff;

  reg [`FRCH_REPLY_W-1:0] rep;
  reg [3:0] rep_len;
  reg nxt_flag_we;
  reg nxt_cfg_h_we;
  reg nxt_cfg_l_we;
  reg nxt_sw_we;
  reg nxt_cfg_save;
  reg nxt_page_save;
  reg [15:0] word_src;
  reg [15:0] hex_word;
  reg hex_ok;
  reg [3:0] hex_base;
  reg [4:0] hex_dig;
  integer k;
  integer j;

  wire busy;
  wire take = rx_valid_i && rx_ready_o;
  // Temperature passed through untouched as a 10-bit signed field
  wire [15:0] temp_word = {6'h00, temp_data_i}; // see (RULE8) (RULE9)

  // New bytes wait while a reply is out or a frame is being executed
  assign rx_ready_o = !busy && !exec_ff;
  assign flag_word_o = flag_ff;
  assign cfg_high_o = cfg_h_ff;
  assign cfg_low_o = cfg_l_ff;
  assign switch_pos_o = sw_ff;
  assign cfg_save_o = cfg_save_ff;
  assign page_save_o = page_save_ff;
  assign page_sel_o = page_ff;

  // Frame collector; a fresh STX always restarts the frame
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_ff <= 4'h0;
      in_frame_ff <= 1'b0;
      ovf_ff <= 1'b0;
      exec_ff <= 1'b0;
    end else begin
      exec_ff <= 1'b0;
      if (take) begin
        if (rx_data_i == `FRCH_STX) begin
          in_frame_ff <= 1'b1;
          cnt_ff <= 4'h0;
          ovf_ff <= 1'b0;
        end else if (in_frame_ff) begin
          if (rx_data_i == `FRCH_ETX) begin
            in_frame_ff <= 1'b0;
            exec_ff <= 1'b1;
          end else if (cnt_ff == `FRCH_BODY_MAX) begin
            ovf_ff <= 1'b1; // Too long; answered with NAK
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
      end
    end
  end

  // Body store, one flop byte per slot
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_body
      always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
          body_ff[gi] <= 8'h00;
        else if (take && in_frame_ff && rx_data_i != `FRCH_STX &&
                 rx_data_i != `FRCH_ETX && cnt_ff == gi)
          body_ff[gi] <= rx_data_i;
      end
    end
  endgenerate

  // Value field: four hex chars starting at body slot hex_base
  // Own loop index, so the decoder's loop keeps a single driver
  always @* begin
    hex_base = (body_ff[2] == `FRCH_CH_C) ? 4'h4 : 4'h3;
    hex_ok = 1'b1;
    hex_word = 16'h0000;
    hex_dig = 5'h00;
    for (j = 0; j < 4; j = j + 1) begin
      hex_dig = hex_val(body_ff[hex_base + j]);
      hex_ok = hex_ok & hex_dig[4];
      hex_word = {hex_word[11:0], hex_dig[3:0]};
    end
  end

  // Command decoder and reply builder
  always @* begin
    rep = {`FRCH_REPLY_W{1'b0}};
    rep[7:0] = `FRCH_STX;
    rep[15:8] = `FRCH_NAK; // see (RULE14)
    rep[23:16] = `FRCH_ETX;
    rep_len = 4'h3;
    nxt_flag_we = 1'b0;
    nxt_cfg_h_we = 1'b0;
    nxt_cfg_l_we = 1'b0;
    nxt_sw_we = 1'b0;
    nxt_cfg_save = 1'b0;
    nxt_page_save = 1'b0;
    word_src = 16'h0000;
    if (!ovf_ff && body_ff[0] == `FRCH_CH_W && body_ff[1] == `FRCH_CH_M &&
        body_ff[2] == `FRCH_CH_F && cnt_ff == 4'h7 && hex_ok) begin
      nxt_flag_we = 1'b1; // see (RULE1) (RULE2)
      rep[15:8] = `FRCH_ACK; // see (RULE3)
    end else if (!ovf_ff && body_ff[0] == `FRCH_CH_W &&
                 body_ff[1] == `FRCH_CH_M && body_ff[2] == `FRCH_CH_C &&
                 cnt_ff == 4'h8 && hex_ok &&
                 (body_ff[3] == `FRCH_CH_H || body_ff[3] == `FRCH_CH_L)) begin
      nxt_cfg_h_we = (body_ff[3] == `FRCH_CH_H); // see (RULE12)
      nxt_cfg_l_we = (body_ff[3] == `FRCH_CH_L);
      rep[15:8] = `FRCH_ACK; // see (RULE3)
    end else if (!ovf_ff && body_ff[0] == `FRCH_CH_S &&
                 body_ff[1] == `FRCH_CH_M && body_ff[2] == `FRCH_CH_C &&
                 cnt_ff == 4'h3) begin
      nxt_cfg_save = 1'b1; // see (RULE6)
      rep[15:8] = `FRCH_ACK;
    end else if (!ovf_ff && body_ff[0] == `FRCH_CH_W && cnt_ff == 4'h2 &&
                 body_ff[1] >= `FRCH_CH_A && body_ff[1] <= `FRCH_CH_F) begin
      nxt_page_save = 1'b1; // see (RULE13)
      rep[15:8] = `FRCH_ACK;
    end else if (!ovf_ff && body_ff[0] == `FRCH_CH_W &&
                 body_ff[1] == `FRCH_CH_M && body_ff[2] == `FRCH_CH_S &&
                 body_ff[3] == `FRCH_CH_W && cnt_ff == 4'h5 &&
                 body_ff[4] >= `FRCH_CH_0 && body_ff[4] <= `FRCH_CH_9) begin
      nxt_sw_we = 1'b1; // see (RULE11)
      rep[15:8] = `FRCH_ACK;
    end else if (!ovf_ff && body_ff[0] == `FRCH_CH_R &&
                 body_ff[1] == `FRCH_CH_M && body_ff[2] == `FRCH_CH_S &&
                 body_ff[3] == `FRCH_CH_W && cnt_ff == 4'h4) begin
      rep[15:8] = `FRCH_ACK; // see (RULE10)
      rep[23:16] = sw_ff;
      rep[31:24] = `FRCH_ETX;
      rep_len = 4'h4;
    end else if (!ovf_ff && body_ff[0] == `FRCH_CH_R &&
                 ((body_ff[1] == `FRCH_CH_M && body_ff[2] == `FRCH_CH_F &&
                   cnt_ff == 4'h3) ||
                  (body_ff[1] == `FRCH_CH_M && body_ff[2] == `FRCH_CH_C &&
                   cnt_ff == 4'h4 && (body_ff[3] == `FRCH_CH_H ||
                                      body_ff[3] == `FRCH_CH_L)) ||
                  (body_ff[1] == `FRCH_CH_T && body_ff[2] == `FRCH_CH_M &&
                   body_ff[3] == `FRCH_CH_P && cnt_ff == 4'h4))) begin
      // Echo the command letters, then the word as four hex chars
      if (body_ff[1] == `FRCH_CH_T)
        word_src = temp_word; // see (RULE7)
      else if (body_ff[2] == `FRCH_CH_F)
        word_src = flag_ff; // see (RULE5)
      else if (body_ff[3] == `FRCH_CH_H)
        word_src = cfg_h_ff; // see (RULE4)
      else
        word_src = cfg_l_ff; // see (RULE4)
      rep[15:8] = `FRCH_ACK;
      for (k = 0; k < 4; k = k + 1) begin
        if (k < cnt_ff)
          rep[8*(k+2) +: 8] = body_ff[k];
      end
      for (k = 0; k < 4; k = k + 1)
        rep[8*(cnt_ff+2+k) +: 8] = hex_chr(word_src[15-4*k -: 4]);
      rep[8*(cnt_ff+6) +: 8] = `FRCH_ETX;
      rep_len = cnt_ff + 4'h7;
    end
  end

  // Register updates happen only in the execute cycle of a good frame
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_ff <= `FRCH_FLAG_RST;
      cfg_h_ff <= `FRCH_CFG_H_RST;
      cfg_l_ff <= `FRCH_CFG_L_RST;
      sw_ff <= `FRCH_SW_RST;
      cfg_save_ff <= 1'b0;
      page_save_ff <= 1'b0;
      page_ff <= 8'h00;
    end else begin
      cfg_save_ff <= exec_ff && nxt_cfg_save;
      page_save_ff <= exec_ff && nxt_page_save;
      if (exec_ff && nxt_flag_we)
        flag_ff <= hex_word;
      if (exec_ff && nxt_cfg_h_we)
        cfg_h_ff <= hex_word;
      if (exec_ff && nxt_cfg_l_we)
        cfg_l_ff <= hex_word;
      if (exec_ff && nxt_sw_we)
        sw_ff <= body_ff[4];
      if (exec_ff && nxt_page_save)
        page_ff <= body_ff[1];
    end
  end

  // Reply leaves one cycle after execute, same time as save strobes
  frch_reply_tx u_reply (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(exec_ff),
    .len_i(rep_len),
    .bytes_i(rep),
    .tx_ready_i(tx_ready_i),
    .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o),
    .busy_o(busy)
  );
endmodule

// >>> frch_cmd_handler_props.sv
// Port-level checks on the command handler.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module frch_cmd_handler_props (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  input wire rx_ready_o,
  input wire [7:0] tx_data_o,
  input wire tx_valid_o,
  input wire tx_ready_i,
  input wire [9:0] temp_data_i,
  input wire [15:0] flag_word_o,
  input wire [15:0] cfg_high_o,
  input wire [15:0] cfg_low_o,
  input wire [7:0] switch_pos_o,
  input wire cfg_save_o,
  input wire page_save_o,
  input wire [7:0] page_sel_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Closing byte taken, and last reply byte taken
  wire etx = rx_valid_i && rx_ready_o && rx_data_i == 8'h03;
  wire last = tx_valid_o && tx_ready_i && tx_data_o == 8'h03;
  reply_start_a: assert property (etx |-> ##2 $rose(tx_valid_o) &&
    tx_data_o == 8'h02) else $error("reply late");
  // Long bound covers a stalling host
  ready_low_a: assert property (etx |=> !rx_ready_o throughout
    (##[0:80] last)) else $error("receiver reopened early");
  ready_back_a: assert property (last |=> rx_ready_o)
    else $error("receiver stays closed");
  reply_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("reply byte dropped");
  cfg_save_a: assert property (cfg_save_o |-> $rose(tx_valid_o)
    ##1 !cfg_save_o) else $error("bad save strobe");
  page_save_a: assert property (page_save_o |->
    $rose(tx_valid_o) && page_sel_o inside {[8'h41:8'h46]})
    else $error("bad page strobe");
  flag_write_a: assert property ($changed(flag_word_o) |->
    $rose(tx_valid_o) && !cfg_save_o && !page_save_o)
    else $error("flag word changed oddly");
  cfg_write_a: assert property (
    $changed({cfg_high_o, cfg_low_o}) |-> $rose(tx_valid_o))
    else $error("config changed oddly");
  switch_write_a: assert property ($changed(switch_pos_o) |->
    $rose(tx_valid_o) && switch_pos_o inside {[8'h30:8'h39]})
    else $error("switch changed oddly");
endmodule
bind frch_cmd_handler frch_cmd_handler_props frch_cmd_handler_props_inst (
  .mclk_i, .sys_rst_i, .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o,
  .tx_valid_o, .tx_ready_i, .temp_data_i, .flag_word_o, .cfg_high_o,
  .cfg_low_o, .switch_pos_o, .cfg_save_o, .page_save_o, .page_sel_o);

// >>> frch_host_model.sv
// Host side of the serial command link: sends frames, collects replies.
// Assumes the handler's byte valid/ready ports on the same clock.
`timescale 1ns/1ps
module frch_host_model (
  input wire mclk_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire rx_ready_i,
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output logic tx_ready_o
);
  logic slow = 1'b0;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // Framed command; ready read at negedge so the take edge is known
  task automatic send(input string s);
    for (int i = 0; i <= s.len() + 1; i++) begin
      rx_data_o <= (i == 0) ? 8'h02 : (i > s.len()) ? 8'h03 : s[i-1];
      rx_valid_o <= 1'b1;
      do @(negedge mclk_i); while (!rx_ready_i);
      @(posedge mclk_i);
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o; // Stale data never looks valid
  endtask
  // Reply up to ETX; a slow host stalls two cycles per byte
  task automatic recv(output logic [95:0] r);
    r = '0;
    do begin
      if (slow) begin
        tx_ready_o <= 1'b0;
        repeat (2) @(posedge mclk_i);
      end
      tx_ready_o <= 1'b1;
      do @(negedge mclk_i); while (!tx_valid_i);
      r = {r[87:0], tx_data_i};
      @(posedge mclk_i);
    end while (r[7:0] !== 8'h03);
    tx_ready_o <= 1'b0;
  endtask
endmodule

// >>> flag_register_command_handler_tb.sv
// Self-checking bench for the flag register command handler.
// Assumes the host model and the bound checker compile first.
`timescale 1ns/1ps
module flag_register_command_handler_tb;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [9:0] temp_data_i = 10'h000;
  wire [7:0] rx_data, tx_data, sw_pos, page_sel;
  wire rx_valid, rx_ready, tx_valid, tx_ready, cfg_save, page_save;
  wire [15:0] flag_word, cfg_high, cfg_low;
  int err_total = 0;
  int checks = 0;
  logic [95:0] seen;
  logic [9:0] tv [3] = '{10'h3FF, 10'h1FF, 10'h200};
  string ts [3] = '{"03FF", "01FF", "0200"};
  string pg = "ABCDEF";
  // Command strings of the serial protocol
  string flag_wr = {"WM", "F"};
  string flag_rd = {"RM", "F"};
  string cfg_wr = {"WM", "C"};
  string cfg_rd = {"RM", "C"};
  string cfg_sv = {"SM", "C"};
  string temp_rd = {"RT", "MP"};
  string sw_rd = {"RM", "SW"};
  string sw_wr = {"WM", "SW"};
  int saves = 0;
  int pages = 0;
  frch_cmd_handler frch_cmd_handler_inst (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
    .rx_ready_o(rx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .temp_data_i(temp_data_i),
    .flag_word_o(flag_word), .cfg_high_o(cfg_high), .cfg_low_o(cfg_low),
    .switch_pos_o(sw_pos), .cfg_save_o(cfg_save),
    .page_save_o(page_save), .page_sel_o(page_sel));
  frch_host_model frch_host_model_inst (.mclk_i(mclk_i),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
  // 50 MHz clock
  initial forever #10 mclk_i = ~mclk_i;
  // Save strobes counted, so missing or extra pulses show up
  always @(posedge mclk_i) begin
    if (cfg_save)
      saves <= saves + 1;
    if (page_save)
      pages <= pages + 1;
  end
  task automatic check(input string what, input logic [95:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One command; expected reply built from body or as a refusal
  task automatic run(input string cmd, input string body, input bit ok);
    logic [95:0] exp;
    exp = 96'h02;
    if (ok) begin
      exp = {exp[87:0], 8'h06};
      foreach (body[i]) exp = {exp[87:0], body[i]};
    end else begin
      exp = {exp[87:0], 8'h15};
    end
    exp = {exp[87:0], 8'h03};
    frch_host_model_inst.send(cmd);
    frch_host_model_inst.recv(seen);
    check("reply", seen, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog well above the expected run of several hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    run(sw_rd, "0", 1);
    run({flag_wr, "12aB"}, "", 1);
    check("flag", flag_word, 16'h12AB);
    check("saves", saves + pages, 0);
    run(flag_rd, {flag_rd, "12AB"}, 1);
    run({flag_wr, "12G4"}, "", 0);
    run({flag_wr, "123"}, "", 0);
    run({flag_wr, "123456"}, "", 0);
    run({cfg_wr, "X1234"}, "", 0);
    run(flag_rd, {flag_rd, "12AB"}, 1);
    frch_host_model_inst.slow = 1'b1;
    run({cfg_wr, "H5A5A"}, "", 1);
    run({cfg_wr, "Lc3C3"}, "", 1);
    run({cfg_rd, "H"}, {cfg_rd, "H5A5A"}, 1);
    run({cfg_rd, "L"}, {cfg_rd, "LC3C3"}, 1);
    check("saves", saves, 0);
    run(cfg_sv, "", 1);
    check("cfg", {cfg_high, cfg_low}, 32'h5A5AC3C3);
    check("saves", saves, 1);
    // Negative, largest and smallest temperature codes
    for (int i = 0; i < 3; i++) begin
      temp_data_i <= tv[i];
      run(temp_rd, {temp_rd, ts[i]}, 1);
    end
    run({sw_wr, "7"}, "", 1);
    check("switch", sw_pos, 8'h37);
    run(sw_rd, "7", 1);
    run({sw_wr, "Z"}, "", 0);
    for (int i = 0; i < 6; i++) begin
      run({"W", pg.substr(i, i)}, "", 1);
      check("page", page_sel, pg[i]);
    end
    frch_host_model_inst.slow = 1'b0;
    run("WG", "", 0);
    check("pages", pages, 6);
    run({"rm", "f"}, "", 0);
    finish_test;
  end
endmodule
